// ===== hw/usb_spi_port_defs.vh
// Constant definitions shared by the SPI register port and its testbench.
`ifndef USB_SPI_PORT_DEFS_VH
`define USB_SPI_PORT_DEFS_VH

// Register addresses carried in the command byte.
`define REG_EP2_FIFO 5'h02
`define REG_EP3_FIFO 5'h03
`define REG_EP2_COUNT 5'h07
`define REG_EP3_COUNT 5'h08
`define REG_STALL 5'h09
`define REG_TOGGLE 5'h0A
`define REG_PIN_CTRL 5'h11
`define REG_FN_ADDR 5'h13
`define REG_GEN_IO 5'h14

// Command byte layout.
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 3
`define CMD_DIR_BIT 1
`define CMD_ACK_BIT 0

// Field positions inside registers.
`define TOG_EP2_DIS 6
`define TOG_EP3_DIS 7
`define PIN_EP2_NAK 6
`define PIN_EP3_NAK 7
`define PIN_FULL_DUPLEX 4
`define STALL_ACK_BIT 6
`define GPIO_IN_LSB 4
`define GPIO_IN_MSB 6
`define COUNT_MSB 6

// Reset values and bit-counter constants.
`define BYTE_ZERO 8'h00
`define COUNT_ZERO 7'h00
`define BIT_CNT_ZERO 3'h0
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_STEP 3'h1

`endif

// ===== hw/sync_2ff.v
// Two-flop synchroniser for a bundle of independent level inputs.
`timescale 1ns/1ps
module sync_2ff #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire rst_b,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== hw/byte_ram.v
// Byte-wide memory with one write port and one registered read port.
`timescale 1ns/1ps
module byte_ram #(
    parameter ADDR_W = 6
) (
    input wire clock,
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:(1<<ADDR_W)-1];

    // Contents have no reset; the owner clears them by a write sweep.
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== hw/usb_spi_in_port.v
// SPI slave register port with IN endpoint 2 and 3 buffering and related register bits.
//
// Overview of operation
// R1: Toggle/disable bit 6 blocks all endpoint 2 IN traffic; cleared by every reset.
// R2: Toggle/disable bit 7 blocks all endpoint 3 IN traffic; cleared by every reset.
// R3: Disabled endpoints ignore host traffic entirely; endpoint 0 cannot be disabled.
// R4: Endpoint 2 NAK answer sets pin-control bit 6; writing 1 clears it.
// R5: Endpoint 3 NAK answer sets pin-control bit 7; writing 1 clears it.
// R6: NAK flags are polled only, no interrupt path, cleared by every reset.
// R7: Writing the endpoint 2 byte count after filling arms that buffer.
// R8: Writing the endpoint 3 byte count after filling arms endpoint 3.
// R9: Endpoint 2 uses two 64-byte buffers filled byte by byte over SPI.
// R10: Endpoint 3 uses one 64-byte buffer filled over SPI and sent on IN.
// R11: Buffers clear on power-on and chip reset only; byte counts clear on all resets, send counts on power-on only.
// R12: Pin-control bit 4 selects full duplex; only power-on resets it to half.
// R13: Half duplex returns read data on the master-out pin; master-in floats.
// R14: Full duplex shifts eight status bits out during the command byte.
// R15: Command byte holds address, zero bit, direction and acknowledge-status value.
// R16: Command bit 0 lands in the stall register acknowledge-status bit unless a chip or bus reset falls in the same cycle.
// R17: Every byte moves most significant bit first.
// R18: Each further eight clocks move one byte to the same register while selected.
// R19: Input sampled on rising serial clock, output changed on falling edge.
// R20: Chip select low starts a cycle; chip select high ends it.
// R21: Clock modes (0,0) and (1,1) both work without a mode input.
// R22: Function address loads from the USB engine, clears on chip/bus reset.
// R23: General I/O bits 4 to 6 show live input pins; writes ignored.
// R24: An armed endpoint sends data on the next IN; unarmed answers NAK.
// R25: Unimplemented addresses read zero and ignore writes.
`timescale 1ns/1ps
`include "usb_spi_port_defs.vh"
module usb_spi_in_port #(
    parameter FIFO_AW = 6
) (
    input wire clock,
    input wire rst_b,
    input wire chip_reset,
    input wire bus_reset,
    input wire sclk,
    input wire cs_b,
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe_b,
    output reg miso_out,
    output reg miso_oe_b,
    input wire [2:0] gp_input,
    input wire [7:0] irq_status,
    input wire ep2_in_request,
    input wire ep2_in_done,
    output reg ep2_in_send,
    output reg ep2_in_nak,
    output reg ep2_in_send_buf,
    output reg [6:0] ep2_in_send_count,
    input wire ep3_in_request,
    input wire ep3_in_done,
    output reg ep3_in_send,
    output reg ep3_in_nak,
    output reg [6:0] ep3_in_send_count,
    input wire [FIFO_AW:0] ep2_rd_addr,
    output wire [7:0] ep2_rd_data,
    input wire [FIFO_AW-1:0] ep3_rd_addr,
    output wire [7:0] ep3_rd_data,
    input wire set_address_done,
    input wire [6:0] new_address,
    output reg [6:0] usb_function_address,
    output reg ctrl_ack_status,
    output reg ep2_in_disable,
    output reg ep3_in_disable
);
    reg rst_meta_b, rst_sync_b;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end
    // Pins from the master and the general inputs pass two flops first.
    wire [5:0] pins_sync;
    sync_2ff #(.WIDTH(6), .RESET_VALUE(6'h3F)) u_pin_sync (
        .clock(clock),
        .rst_b(rst_sync_b),
        .async_in({gp_input, mosi_in, cs_b, sclk}),
        .sync_out(pins_sync)
    );
    wire sclk_s = pins_sync[0];
    wire cs_b_s = pins_sync[1];
    wire mosi_s = pins_sync[2];
    wire [2:0] gp_s = pins_sync[5:3];
    wire bus_clear = chip_reset | bus_reset;
    reg sclk_q, cs_b_q, in_cmd, dir_write, full_duplex_select, ep2_in_nak_flag, ep3_in_nak_flag;
    reg ep2_fill_buf, ep2_send_sel, ep3_armed, clr_busy;
    reg [2:0] bit_cnt;
    reg [4:0] reg_addr;
    reg [7:0] tx_byte;
    reg [6:0] rx_shift, ep2_in_byte_count, ep3_in_byte_count, ep2_count_a, ep2_count_b;
    reg [1:0] ep2_armed;
    reg [FIFO_AW-1:0] ep2_wr_ptr, ep3_wr_ptr;
    reg [FIFO_AW:0] clr_addr;
    // A rising clock is an input strobe, a falling one an output strobe. With the
    // sampling done only on rising edges the idle clock level does not matter.
    wire sclk_rise = sclk_s & ~sclk_q; // R19 R21
    wire sclk_fall = ~sclk_s & sclk_q; // R19
    wire cs_start = ~cs_b_s & cs_b_q; // R20
    wire [7:0] rx_full = {rx_shift, mosi_s}; // R17
    wire byte_done = sclk_rise & ~cs_b_s & (bit_cnt == `BIT_CNT_LAST); // R18
    wire cmd_done = byte_done & in_cmd;
    wire reg_write = byte_done & ~in_cmd & dir_write; // R18
    wire reg_read_next = byte_done & (in_cmd ? ~rx_full[`CMD_DIR_BIT] : ~dir_write);
    wire [4:0] next_addr = in_cmd ? rx_full[`CMD_ADDR_MSB:`CMD_ADDR_LSB] : reg_addr; // R15
    wire read_phase = ~in_cmd & ~dir_write;
    wire tx_bit = tx_byte[~bit_cnt]; // R17
    wire wr_ep2_fifo = reg_write & (reg_addr == `REG_EP2_FIFO);
    wire wr_ep3_fifo = reg_write & (reg_addr == `REG_EP3_FIFO);
    wire wr_ep2_count = reg_write & (reg_addr == `REG_EP2_COUNT);
    wire wr_ep3_count = reg_write & (reg_addr == `REG_EP3_COUNT);
    wire wr_pin_ctrl = reg_write & (reg_addr == `REG_PIN_CTRL);
    wire wr_toggle = reg_write & (reg_addr == `REG_TOGGLE);
    wire wr_stall = reg_write & (reg_addr == `REG_STALL);
    // Read data for a register; the buffer ports are write-only from this side.
    function [7:0] read_value;
        input [4:0] addr;
        begin
            read_value = `BYTE_ZERO;
            case (addr)
                `REG_EP2_COUNT: read_value[`COUNT_MSB:0] = ep2_in_byte_count;
                `REG_EP3_COUNT: read_value[`COUNT_MSB:0] = ep3_in_byte_count;
                `REG_STALL: read_value[`STALL_ACK_BIT] = ctrl_ack_status;
                `REG_TOGGLE: begin
                    read_value[`TOG_EP2_DIS] = ep2_in_disable;
                    read_value[`TOG_EP3_DIS] = ep3_in_disable;
                end
                `REG_PIN_CTRL: begin
                    read_value[`PIN_EP2_NAK] = ep2_in_nak_flag;
                    read_value[`PIN_EP3_NAK] = ep3_in_nak_flag;
                    read_value[`PIN_FULL_DUPLEX] = full_duplex_select;
                end
                `REG_FN_ADDR: read_value[`COUNT_MSB:0] = usb_function_address;
                `REG_GEN_IO: read_value[`GPIO_IN_MSB:`GPIO_IN_LSB] = gp_s; // R23
                default: read_value = `BYTE_ZERO; // R25
            endcase
        end
    endfunction
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sclk_q <= 1'b0;
            cs_b_q <= 1'b1;
            bit_cnt <= `BIT_CNT_ZERO;
            rx_shift <= `COUNT_ZERO;
            in_cmd <= 1'b1;
            reg_addr <= 5'h00;
            dir_write <= 1'b0;
            tx_byte <= `BYTE_ZERO;
        end else begin
            sclk_q <= sclk_s;
            cs_b_q <= cs_b_s;
            if (cs_b_s) begin
                bit_cnt <= `BIT_CNT_ZERO; // R20
                in_cmd <= 1'b1;
                dir_write <= 1'b0;
            end else begin
                if (cs_start)
                    tx_byte <= irq_status; // R14
                if (sclk_rise) begin
                    rx_shift <= rx_full[6:0];
                    bit_cnt <= bit_cnt + `BIT_CNT_STEP;
                end
                if (cmd_done) begin
                    reg_addr <= next_addr; // R15
                    dir_write <= rx_full[`CMD_DIR_BIT];
                    in_cmd <= 1'b0;
                end
                if (reg_read_next)
                    tx_byte <= read_value(next_addr); // R18
                else if (byte_done)
                    tx_byte <= `BYTE_ZERO;
            end
        end
    end
    // Pin drivers: outputs change only on the falling clock, at selection or at deselection.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mosi_out <= 1'b0;
            mosi_oe_b <= 1'b1;
            miso_out <= 1'b0;
            miso_oe_b <= 1'b1;
        end else if (cs_b_s) begin
            mosi_oe_b <= 1'b1;
            miso_oe_b <= 1'b1;
        end else if (cs_start) begin
            // The first status bit must be valid before the first rising edge.
            miso_out <= irq_status[7]; // R14 R21
            miso_oe_b <= ~full_duplex_select; // R13
            mosi_oe_b <= 1'b1;
        end else if (sclk_fall) begin
            miso_out <= tx_bit; // R19
            mosi_out <= tx_bit;
            miso_oe_b <= ~full_duplex_select; // R13
            mosi_oe_b <= ~(~full_duplex_select & read_phase); // R13
        end
    end
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            full_duplex_select <= 1'b0; // R12
            ctrl_ack_status <= 1'b0;
            ep2_in_disable <= 1'b0;
            ep3_in_disable <= 1'b0;
            usb_function_address <= `COUNT_ZERO;
        end else begin
            if (wr_pin_ctrl)
                full_duplex_select <= rx_full[`PIN_FULL_DUPLEX]; // R12
            if (bus_clear) begin
                ctrl_ack_status <= 1'b0;
                ep2_in_disable <= 1'b0; // R1
                ep3_in_disable <= 1'b0; // R2
                usb_function_address <= `COUNT_ZERO; // R22
            end else begin
                if (cmd_done)
                    ctrl_ack_status <= rx_full[`CMD_ACK_BIT]; // R16
                else if (wr_stall)
                    ctrl_ack_status <= rx_full[`STALL_ACK_BIT];
                if (wr_toggle) begin
                    ep2_in_disable <= rx_full[`TOG_EP2_DIS]; // R1
                    ep3_in_disable <= rx_full[`TOG_EP3_DIS]; // R2
                end
                if (set_address_done)
                    usb_function_address <= new_address; // R22
            end
        end
    end
    // Endpoint 2: the master fills one buffer while the engine may send the other.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ep2_in_byte_count <= `COUNT_ZERO;
            ep2_count_a <= `COUNT_ZERO;
            ep2_count_b <= `COUNT_ZERO;
            ep2_armed <= 2'h0;
            ep2_fill_buf <= 1'b0;
            ep2_send_sel <= 1'b0;
            ep2_wr_ptr <= {FIFO_AW{1'b0}};
            ep2_in_send <= 1'b0;
            ep2_in_nak <= 1'b0;
            ep2_in_send_buf <= 1'b0;
            ep2_in_send_count <= `COUNT_ZERO;
            ep2_in_nak_flag <= 1'b0;
        end else if (bus_clear) begin
            ep2_in_byte_count <= `COUNT_ZERO; // R11
            ep2_count_a <= `COUNT_ZERO;
            ep2_count_b <= `COUNT_ZERO;
            ep2_armed <= 2'h0;
            ep2_fill_buf <= 1'b0;
            ep2_send_sel <= 1'b0;
            ep2_wr_ptr <= {FIFO_AW{1'b0}};
            ep2_in_send <= 1'b0;
            ep2_in_nak <= 1'b0;
            ep2_in_nak_flag <= 1'b0; // R6
        end else begin
            ep2_in_send <= 1'b0;
            ep2_in_nak <= 1'b0;
            if (wr_ep2_fifo && !clr_busy)
                ep2_wr_ptr <= ep2_wr_ptr + {{(FIFO_AW-1){1'b0}}, 1'b1}; // R9
            // A disabled endpoint neither sends nor NAKs.
            if (ep2_in_request && !ep2_in_disable) begin // R3
                if (ep2_armed[ep2_send_sel]) begin
                    ep2_in_send <= 1'b1; // R24
                    ep2_in_send_buf <= ep2_send_sel;
                    ep2_in_send_count <= ep2_send_sel ? ep2_count_b : ep2_count_a;
                end else begin
                    ep2_in_nak <= 1'b1; // R24
                end
            end
            if (ep2_in_done) begin
                ep2_armed[ep2_send_sel] <= 1'b0;
                ep2_send_sel <= ~ep2_send_sel;
            end
            if (wr_ep2_count) begin
                ep2_in_byte_count <= rx_full[`COUNT_MSB:0];
                if (ep2_fill_buf)
                    ep2_count_b <= rx_full[`COUNT_MSB:0];
                else
                    ep2_count_a <= rx_full[`COUNT_MSB:0];
                ep2_armed[ep2_fill_buf] <= 1'b1; // R7
                ep2_fill_buf <= ~ep2_fill_buf; // R9
                ep2_wr_ptr <= {FIFO_AW{1'b0}};
            end
            // A new NAK wins over a clear written in the same cycle.
            if (ep2_in_request && !ep2_in_disable && !ep2_armed[ep2_send_sel])
                ep2_in_nak_flag <= 1'b1; // R4
            else if (wr_pin_ctrl && rx_full[`PIN_EP2_NAK])
                ep2_in_nak_flag <= 1'b0; // R4
        end
    end
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ep3_in_byte_count <= `COUNT_ZERO;
            ep3_armed <= 1'b0;
            ep3_wr_ptr <= {FIFO_AW{1'b0}};
            ep3_in_send <= 1'b0;
            ep3_in_nak <= 1'b0;
            ep3_in_send_count <= `COUNT_ZERO;
            ep3_in_nak_flag <= 1'b0;
        end else if (bus_clear) begin
            ep3_in_byte_count <= `COUNT_ZERO; // R11
            ep3_armed <= 1'b0;
            ep3_wr_ptr <= {FIFO_AW{1'b0}};
            ep3_in_send <= 1'b0;
            ep3_in_nak <= 1'b0;
            ep3_in_nak_flag <= 1'b0; // R6
        end else begin
            ep3_in_send <= 1'b0;
            ep3_in_nak <= 1'b0;
            if (wr_ep3_fifo && !clr_busy)
                ep3_wr_ptr <= ep3_wr_ptr + {{(FIFO_AW-1){1'b0}}, 1'b1}; // R10
            if (ep3_in_request && !ep3_in_disable) begin // R3
                if (ep3_armed) begin
                    ep3_in_send <= 1'b1; // R10 R24
                    ep3_in_send_count <= ep3_in_byte_count;
                end else begin
                    ep3_in_nak <= 1'b1; // R24
                end
            end
            if (ep3_in_done)
                ep3_armed <= 1'b0;
            if (wr_ep3_count) begin
                ep3_in_byte_count <= rx_full[`COUNT_MSB:0];
                ep3_armed <= 1'b1; // R8
                ep3_wr_ptr <= {FIFO_AW{1'b0}};
            end
            if (ep3_in_request && !ep3_in_disable && !ep3_armed)
                ep3_in_nak_flag <= 1'b1; // R5
            else if (wr_pin_ctrl && rx_full[`PIN_EP3_NAK])
                ep3_in_nak_flag <= 1'b0; // R5
        end
    end
    // Buffer clearing sweeps one address per cycle, so the buffers are not
    // cleared instantly; buffer writes from the master during the sweep are lost.
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            clr_busy <= 1'b1;
            clr_addr <= {(FIFO_AW+1){1'b0}};
        end else if (chip_reset) begin
            clr_busy <= 1'b1; // R11
            clr_addr <= {(FIFO_AW+1){1'b0}};
        end else if (clr_busy) begin
            clr_addr <= clr_addr + {{FIFO_AW{1'b0}}, 1'b1};
            if (&clr_addr)
                clr_busy <= 1'b0;
        end
    end
    byte_ram #(.ADDR_W(FIFO_AW + 1)) u_ep2_ram (
        .clock(clock),
        .wr_en(clr_busy | wr_ep2_fifo),
        .wr_addr(clr_busy ? clr_addr : {ep2_fill_buf, ep2_wr_ptr}),
        .wr_data(clr_busy ? `BYTE_ZERO : rx_full),
        .rd_addr(ep2_rd_addr),
        .rd_data(ep2_rd_data)
    );
    byte_ram #(.ADDR_W(FIFO_AW)) u_ep3_ram (
        .clock(clock),
        .wr_en(clr_busy | wr_ep3_fifo),
        .wr_addr(clr_busy ? clr_addr[FIFO_AW-1:0] : ep3_wr_ptr),
        .wr_data(clr_busy ? `BYTE_ZERO : rx_full),
        .rd_addr(ep3_rd_addr),
        .rd_data(ep3_rd_data)
    );
endmodule

// ===== tb/usb_spi_in_port_properties.sv
// Concurrent checks on the register port.
`timescale 1ns/1ps
module usb_spi_in_port_properties (
    input wire clock,
    input wire rst_b,
    input wire chip_reset,
    input wire bus_reset,
    input wire cs_b,
    input wire ep2_in_request,
    input wire ep3_in_request,
    input wire ep2_in_send,
    input wire ep2_in_nak,
    input wire ep3_in_send,
    input wire ep3_in_nak,
    input wire ep2_in_disable,
    input wire ep3_in_disable,
    input wire set_address_done,
    input wire [6:0] new_address,
    input wire [6:0] usb_function_address,
    input wire mosi_oe_b,
    input wire miso_oe_b
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    wire any_rst = chip_reset | bus_reset;
    sequence s_ep2_live;
        ep2_in_request && !ep2_in_disable && !any_rst;
    endsequence
    sequence s_ep3_live;
        ep3_in_request && !ep3_in_disable && !any_rst;
    endsequence
    sequence s_idle;
        cs_b [*8];
    endsequence
    a_ep2_answers: assert property (s_ep2_live |=> ep2_in_send != ep2_in_nak)
        else $error("ep2 request unanswered");
    a_ep3_answers: assert property (s_ep3_live |=> ep3_in_send != ep3_in_nak)
        else $error("ep3 request unanswered");
    a_no_stray_answer: assert property (ep2_in_send || ep2_in_nak |-> $past(ep2_in_request))
        else $error("ep2 answer without request");
    a_ep2_silent: assert property (ep2_in_request && ep2_in_disable |=> !ep2_in_send && !ep2_in_nak)
        else $error("disabled ep2 answered");
    a_ep3_silent: assert property (ep3_in_request && ep3_in_disable |=> !ep3_in_send && !ep3_in_nak)
        else $error("disabled ep3 answered");
    a_reset_clears: assert property (any_rst |=> usb_function_address == 7'h00 && !ep2_in_disable && !ep3_in_disable)
        else $error("reset left state set");
    a_addr_load: assert property (set_address_done && !any_rst |=> usb_function_address == $past(new_address))
        else $error("function address not loaded");
    a_addr_hold: assert property (!set_address_done && !any_rst |=> $stable(usb_function_address))
        else $error("function address changed");
    a_idle_quiet: assert property (s_idle |-> mosi_oe_b && miso_oe_b)
        else $error("pin driven while deselected");
    a_one_driver: assert property (mosi_oe_b || miso_oe_b)
        else $error("both data pins driven");
endmodule
bind usb_spi_in_port usb_spi_in_port_properties i_props (.*);

// ===== tb/spi_master_model.sv
// SPI master model for the register port.
`timescale 1ns/1ps
module spi_master_model (
    input wire clock,
    input wire din,
    output reg sclk,
    output reg cs_b,
    output reg mosi,
    output reg mosi_en
);
    initial begin
        sclk = 1'h0;
        cs_b = 1'h1;
        mosi = 1'h0;
        mosi_en = 1'h1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Data bytes count up from wd; st is the command-time byte.
    task automatic xfer(input bit cpol, input [7:0] cmd, input [7:0] wd, input int nb,
                        output [7:0] st, output [7:0] rd);
        logic [7:0] b;
        @(posedge clock);
        sclk <= cpol;
        mosi_en <= 1'h1;
        wait_clk(4);
        cs_b <= 1'h0;
        wait_clk(4);
        for (int i = 0; i <= nb; i++) begin
            b = (i == 0) ? cmd : wd + 8'(i - 1);
            for (int k = 7; k >= 0; k--) begin
                sclk <= 1'h0;
                mosi <= b[k];
                mosi_en <= (i == 0) || cmd[1];
                wait_clk(4);
                sclk <= 1'h1;
                wait_clk(4);
                rd = {rd[6:0], din};
            end
            if (i == 0) st = rd;
        end
        sclk <= cpol;
        wait_clk(4);
        cs_b <= 1'h1;
        wait_clk(6);
    endtask
endmodule

// ===== tb/usb_spi_in_port_tb.sv
// Self-checking bench for the SPI register port.
`timescale 1ns/1ps
`include "usb_spi_port_defs.vh"
module usb_spi_in_port_tb;
    logic clock = 1'h0, rst_b = 1'h0, chip_reset = 1'h0, bus_reset = 1'h0, set_address_done = 1'h0;
    logic ep2_in_request = 1'h0, ep3_in_request = 1'h0, ep2_in_done = 1'h0, ep3_in_done = 1'h0;
    logic [2:0] gp_input = 3'h7;
    logic [7:0] irq_status = 8'h00, st, rv;
    logic [6:0] ep2_rd_addr = 7'h00, new_address = 7'h00, scnt;
    logic [5:0] ep3_rd_addr = 6'h00;
    logic sent, nakd, sbuf, b0;
    wire mosi_out, mosi_oe_b, miso_out, miso_oe_b, ep2_in_send, ep2_in_nak, ep2_in_send_buf, ep3_in_send;
    wire ep3_in_nak, ctrl_ack_status, ep2_in_disable, ep3_in_disable, sclk, cs_b, m_mosi, m_en;
    wire [6:0] ep2_in_send_count, ep3_in_send_count, usb_function_address;
    wire [7:0] ep2_rd_data, ep3_rd_data;
    // A released pin shows the inverse level so stale data cannot pass.
    wire mosi_pin = !mosi_oe_b ? mosi_out : (m_en ? m_mosi : ~m_mosi);
    wire din = miso_oe_b ? mosi_pin : miso_out;
    int n_fail = 0;
    int checks = 0;
    always #5 clock = ~clock;
    spi_master_model i_master (.clock, .din, .sclk, .cs_b, .mosi(m_mosi), .mosi_en(m_en));
    usb_spi_in_port i_usb_spi_in_port (.*, .mosi_in(mosi_pin));
    task automatic wrap_up;
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input [7:0] got, input [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [4:0] a, input [7:0] d, input int n = 1);
        i_master.xfer(1'h0, {a, 3'h2}, d, n, st, rv);
    endtask
    task automatic rd(input [4:0] a);
        i_master.xfer(1'h0, {a, 3'h0}, 8'h00, 1, st, rv);
    endtask
    // One-cycle pulse: bit 0/1 request ep2/ep3, 2/3 done ep2/ep3, 4 chip, 5 bus reset, 6 address load.
    task automatic pulse(input [6:0] v);
        @(posedge clock);
        {set_address_done, bus_reset, chip_reset, ep3_in_done, ep2_in_done, ep3_in_request, ep2_in_request} <= v;
        @(posedge clock);
        {set_address_done, bus_reset, chip_reset, ep3_in_done, ep2_in_done, ep3_in_request, ep2_in_request} <= 7'h00;
        #1;
        sent = v[1] ? ep3_in_send : ep2_in_send;
        nakd = v[1] ? ep3_in_nak : ep2_in_nak;
        scnt = v[1] ? ep3_in_send_count : ep2_in_send_count;
        sbuf = ep2_in_send_buf;
    endtask
    task automatic mem(input bit ep3, input [6:0] a, input [7:0] exp);
        @(posedge clock);
        ep2_rd_addr <= a;
        ep3_rd_addr <= a[5:0];
        repeat (3) @(posedge clock);
        chk(ep3 ? ep3_rd_data : ep2_rd_data, exp);
    endtask
    task automatic t_disable;
        wr(`REG_TOGGLE, 8'hC0);
        chk({6'h00, ep3_in_disable, ep2_in_disable}, 8'h03);
        pulse(7'h01);
        chk({6'h00, sent, nakd}, 8'h00);
        pulse(7'h02);
        chk({6'h00, sent, nakd}, 8'h00);
        wr(`REG_TOGGLE, 8'h00);
        chk({6'h00, ep3_in_disable, ep2_in_disable}, 8'h00);
    endtask
    task automatic t_ep2;
        wr(`REG_EP2_FIFO, 8'h81, 4);
        wr(`REG_EP2_COUNT, 8'h04);
        wr(`REG_EP2_FIFO, 8'h91, 2);
        wr(`REG_EP2_COUNT, 8'h02);
        pulse(7'h01);
        b0 = sbuf;
        chk({sent, nakd, scnt[5:0]}, 8'h84);
        mem(1'h0, {b0, 6'h02}, 8'h83);
        pulse(7'h04);
        pulse(7'h01);
        chk({sent, nakd, scnt[5:0]}, 8'h82);
        mem(1'h0, {~b0, 6'h01}, 8'h92);
        pulse(7'h04);
        pulse(7'h01);
        chk({sent, nakd, 6'h00}, 8'h40);
        rd(`REG_PIN_CTRL);
        chk(rv & 8'hC0, 8'h40);
        wr(`REG_PIN_CTRL, 8'h40);
        rd(`REG_PIN_CTRL);
        chk(rv & 8'hC0, 8'h00);
    endtask
    task automatic t_ep3;
        wr(`REG_EP3_FIFO, 8'hA0, 3);
        wr(`REG_EP3_COUNT, 8'h03);
        pulse(7'h02);
        chk({sent, nakd, scnt[5:0]}, 8'h83);
        mem(1'h1, 7'h02, 8'hA2);
        pulse(7'h08);
        pulse(7'h02);
        rd(`REG_PIN_CTRL);
        chk(rv & 8'hC0, 8'h80);
        wr(`REG_PIN_CTRL, 8'h80);
        rd(`REG_PIN_CTRL);
        chk(rv & 8'hC0, 8'h00);
    endtask
    task automatic t_misc;
        i_master.xfer(1'h0, 8'hF9, 8'h00, 0, st, rv);
        chk({7'h00, ctrl_ack_status}, 8'h01);
        gp_input <= 3'h5;
        wr(`REG_GEN_IO, 8'h00);
        chk({7'h00, ctrl_ack_status}, 8'h00);
        rd(`REG_GEN_IO);
        chk(rv & 8'h70, 8'h50);
        wr(5'h1F, 8'h5A);
        rd(5'h1F);
        chk(rv, 8'h00);
    endtask
    task automatic t_resets;
        new_address <= 7'h2B;
        pulse(7'h40);
        wr(`REG_FN_ADDR, 8'h11);
        rd(`REG_FN_ADDR);
        chk(rv, 8'h2B);
        wr(`REG_EP2_COUNT, 8'h05);
        pulse(7'h20);
        rd(`REG_FN_ADDR);
        chk(rv, 8'h00);
        rd(`REG_EP2_COUNT);
        chk(rv, 8'h00);
        mem(1'h0, {b0, 6'h02}, 8'h83);
        pulse(7'h10);
        repeat (140) @(posedge clock);
        mem(1'h0, {b0, 6'h02}, 8'h00);
    endtask
    task automatic t_fdx;
        wr(`REG_PIN_CTRL, 8'h10);
        irq_status <= 8'hA5;
        pulse(7'h20);
        i_master.xfer(1'h1, {`REG_PIN_CTRL, 3'h0}, 8'h00, 1, st, rv);
        chk(st, 8'hA5);
        chk(rv & 8'h10, 8'h10);
        wr(`REG_PIN_CTRL, 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'h1;
        repeat (150) @(posedge clock);
        t_disable();
        t_ep2();
        t_ep3();
        t_misc();
        t_resets();
        t_fdx();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        wrap_up();
    end
endmodule
